// *** rtl/sfc_pkg.sv ***
/*
 * Shared constants and carriers for the slave FIFO packet-commit port.
 * Assumes a 40 MHz system clock and a link clock of at most 48 MHz.
 */
package sfc_pkg;
    localparam int          SYS_CLK_HZ     = 40_000_000;
    localparam int          LINK_CLK_MAX_HZ = 48_000_000;
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 16;
    localparam int          LEN_W          = 11;
    localparam int          PTR_W          = 8;
    localparam int          NUM_FIFO       = 4;
    localparam logic [4:0]  OFS_CONFIG     = 5'h00;
    localparam logic [4:0]  OFS_AUTO_LEN   = 5'h04;
    localparam logic [4:0]  OFS_COMMIT_CNT = 5'h08;
    localparam logic [4:0]  OFS_LAST_PKT   = 5'h0C;
    localparam logic [4:0]  OFS_ECC        = 5'h10;
    localparam logic [1:0]  MODE_PORT      = 2'h0;
    localparam logic [1:0]  MODE_WAVE      = 2'h2;
    localparam logic [1:0]  MODE_SLAVE     = 2'h3;
    localparam logic [10:0] AUTO_LEN_RST   = 11'h200;
    localparam int          LAST_FIFO_POS  = 12;

    typedef struct packed {
        logic        auto_en;
        logic        word_wide;
        logic        async_en;
        logic [1:0]  mode;
        logic [10:0] auto_len;
    } sfc_cfg_t;

    localparam sfc_cfg_t CFG_RST = '{auto_en: 1'b0, word_wide: 1'b0, async_en: 1'b0,
                                     mode: MODE_PORT, auto_len: AUTO_LEN_RST};

    typedef struct packed {
        logic        cs_n;
        logic        wr;
        logic        rd;
        logic        oe;
        logic        commit;
        logic [1:0]  sel;
        logic [15:0] data;
    } sfc_pins_t;

    typedef struct packed {
        logic [1:0]  fifo;
        logic [10:0] len;
        logic [7:0]  ecc;
    } sfc_pkt_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } sfc_bus_st_t;
endpackage

// *** rtl/sfc_slave_fifo.sv ***
/*
 * Slave FIFO port with interface-mode selection and packet commit.
 * Assumes an Avalon-MM master on clk_sys and an external master on the link clock.
 */
// The address map and the Avalon-MM slave port were chosen for this implementation.
// How it works
// - Two-bit mode field picks general port, waveform engine or slave FIFO.
// - After reset the mode field reads general port.
// - Auto mode commits once buffered bytes reach the programmed length.
// - The check-code accumulator runs only for byte-wide transfers.
// - Strobes and output enable act only while chip select is low.
// - Each sampled write stores bus data and advances the write pointer.
`timescale 1ns/1ps
`default_nettype none
module sfc_slave_fifo
    import sfc_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    input  wire logic [sfc_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic                      interface_clock,
    input  wire logic                      slave_chip_select_n,
    input  wire logic                      slave_write_strobe,
    input  wire logic                      slave_read_strobe,
    input  wire logic                      slave_output_enable,
    input  wire logic                      packet_commit_strobe,
    input  wire logic [1:0]                fifo_select_lines,
    input  wire logic [sfc_pkg::DATA_W-1:0] fd_i,
    output logic      [sfc_pkg::DATA_W-1:0] fd_o,
    output logic                           fd_oe
);
    import sfc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    sfc_bus_st_t st_q, st_d;
    sfc_cfg_t    cfg_q, cfg_d;
    logic        cfg_tgl_q, cfg_tgl_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] ccnt_q, ccnt_d;
    sfc_pkt_t    last_q, last_d;
    logic [2:0]  ptgl_sync_q;
    logic        req;
    logic        wr_take;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & (st_q != ST_ACK);
    assign avs_readdata    = rdata_q;
    assign wr_take         = avs_write & (st_q == ST_ACK);

    logic [1:0]  lrst_sync_q;
    logic        l_rst;
    logic [2:0]  ctgl_sync_q;
    sfc_cfg_t    l_cfg_q, l_cfg_d;
    sfc_pins_t   p1_q, p2_q, p3_q;
    logic [LEN_W-1:0] cnt_q [NUM_FIFO];
    logic [LEN_W-1:0] cnt_d [NUM_FIFO];
    logic [AW-1:0]    wptr_q [NUM_FIFO];
    logic [AW-1:0]    wptr_d [NUM_FIFO];
    logic [AW-1:0]    rptr_q [NUM_FIFO];
    logic [AW-1:0]    rptr_d [NUM_FIFO];
    logic [DATA_W-1:0] mem [NUM_FIFO*DEPTH];
    logic [7:0]  ecc_q, ecc_d;
    sfc_pkt_t    pkt_q, pkt_d;
    logic        ptgl_q, ptgl_d;
    logic [DATA_W-1:0] fdo_q, fdo_d;
    logic        oe_q, oe_d;
    logic        act, wr_ev, rd_ev, commit_ev, auto_hit, pkt_go, ecc_on;
    logic [LEN_W-1:0] step, new_cnt;

    // Register bus: one wait cycle, then the answer.
    always_comb begin
        st_d      = ST_IDLE;
        cfg_d     = cfg_q;
        cfg_tgl_d = cfg_tgl_q;
        rdata_d   = rdata_q;
        ccnt_d    = ccnt_q;
        last_d    = last_q;
        case (st_q)
            ST_IDLE: begin
                if (req) begin
                    st_d = ST_ACK;
                end
                rdata_d = 32'h0000_0000;
                case (avs_address)
                    OFS_CONFIG: begin
                        rdata_d[4:0] = {cfg_q.auto_en, cfg_q.word_wide, cfg_q.async_en,
                                        cfg_q.mode};
                    end
                    OFS_AUTO_LEN: begin
                        rdata_d[LEN_W-1:0] = cfg_q.auto_len;
                    end
                    OFS_COMMIT_CNT: begin
                        rdata_d = ccnt_q;
                    end
                    OFS_LAST_PKT: begin
                        rdata_d[LEN_W-1:0]                   = last_q.len;
                        rdata_d[LAST_FIFO_POS+1:LAST_FIFO_POS] = last_q.fifo;
                    end
                    OFS_ECC: begin
                        rdata_d[7:0] = last_q.ecc;
                    end
                    default: begin
                        rdata_d = 32'h0000_0000;
                    end
                endcase
            end
            ST_ACK: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (wr_take && avs_address == OFS_CONFIG && avs_byteenable[0]) begin
            cfg_d.mode      = avs_writedata[1:0];
            cfg_d.async_en  = avs_writedata[2];
            cfg_d.word_wide = avs_writedata[3];
            cfg_d.auto_en   = avs_writedata[4];
            cfg_tgl_d       = ~cfg_tgl_q;
        end
        if (wr_take && avs_address == OFS_AUTO_LEN) begin
            if (avs_byteenable[0]) begin
                cfg_d.auto_len[7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                cfg_d.auto_len[10:8] = avs_writedata[10:8];
            end
            cfg_tgl_d = ~cfg_tgl_q;
        end
        if (ptgl_sync_q[2] != ptgl_sync_q[1]) begin
            ccnt_d = ccnt_q + 32'h0000_0001;
            last_d = pkt_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        ptgl_sync_q <= {ptgl_sync_q[1:0], ptgl_q};
        if (sys_rst) begin
            st_q      <= ST_IDLE;
            cfg_q     <= CFG_RST;
            cfg_tgl_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            ccnt_q    <= 32'h0000_0000;
            last_q    <= '0;
        end else begin
            st_q      <= st_d;
            cfg_q     <= cfg_d;
            cfg_tgl_q <= cfg_tgl_d;
            rdata_q   <= rdata_d;
            ccnt_q    <= ccnt_d;
            last_q    <= last_d;
        end
    end

    // Link side: pins pass two flops, then a third gives the previous level.
    assign l_rst  = lrst_sync_q[1];
    assign act    = (l_cfg_q.mode == MODE_SLAVE) && !p2_q.cs_n;
    assign wr_ev  = act && p2_q.wr && (!l_cfg_q.async_en || !p3_q.wr);
    assign rd_ev  = act && p2_q.rd && (!l_cfg_q.async_en || !p3_q.rd);
    assign commit_ev = act && p2_q.commit && (!l_cfg_q.async_en || !p3_q.commit);
    assign step   = l_cfg_q.word_wide ? 11'h002 : 11'h001;
    assign new_cnt = cnt_q[p2_q.sel] + (wr_ev ? step : 11'h000);
    assign auto_hit = l_cfg_q.auto_en && wr_ev && (l_cfg_q.auto_len != 11'h000)
                      && (new_cnt >= l_cfg_q.auto_len);
    assign pkt_go = auto_hit || (commit_ev && new_cnt != 11'h000);
    assign ecc_on = (l_cfg_q.mode != MODE_PORT) && !l_cfg_q.word_wide;

    always_comb begin
        cnt_d   = cnt_q;
        wptr_d  = wptr_q;
        rptr_d  = rptr_q;
        ecc_d   = ecc_q;
        pkt_d   = pkt_q;
        ptgl_d  = ptgl_q;
        l_cfg_d = l_cfg_q;
        oe_d    = act && p2_q.oe;
        fdo_d   = mem[{p2_q.sel, rptr_q[p2_q.sel]}];
        if (ctgl_sync_q[2] != ctgl_sync_q[1]) begin
            l_cfg_d = cfg_q;
        end
        if (wr_ev) begin
            wptr_d[p2_q.sel] = wptr_q[p2_q.sel] + 1'b1;
            if (ecc_on) begin
                ecc_d = ecc_q ^ p2_q.data[7:0];
            end
        end
        if (rd_ev) begin
            rptr_d[p2_q.sel] = rptr_q[p2_q.sel] + 1'b1;
        end
        cnt_d[p2_q.sel] = new_cnt;
        if (pkt_go) begin
            pkt_d  = '{fifo: p2_q.sel, len: new_cnt, ecc: ecc_d};
            ptgl_d = ~ptgl_q;
            cnt_d[p2_q.sel] = 11'h000;
            ecc_d  = 8'h00;
        end
    end

    always_ff @(posedge interface_clock) begin
        lrst_sync_q <= {lrst_sync_q[0], sys_rst};
        ctgl_sync_q <= {ctgl_sync_q[1:0], cfg_tgl_q};
        p1_q <= '{cs_n: slave_chip_select_n, wr: slave_write_strobe, rd: slave_read_strobe,
                  oe: slave_output_enable, commit: packet_commit_strobe,
                  sel: fifo_select_lines, data: fd_i};
        p2_q <= p1_q;
        p3_q <= p2_q;
        if (wr_ev) begin
            mem[{p2_q.sel, wptr_q[p2_q.sel]}] <= p2_q.data;
        end
        if (l_rst) begin
            l_cfg_q <= CFG_RST;
            ecc_q   <= 8'h00;
            pkt_q   <= '0;
            ptgl_q  <= 1'b0;
            fdo_q   <= 16'h0000;
            oe_q    <= 1'b0;
            for (int i = 0; i < NUM_FIFO; i++) begin
                cnt_q[i]  <= 11'h000;
                wptr_q[i] <= '0;
                rptr_q[i] <= '0;
            end
        end else begin
            l_cfg_q <= l_cfg_d;
            ecc_q   <= ecc_d;
            pkt_q   <= pkt_d;
            ptgl_q  <= ptgl_d;
            fdo_q   <= fdo_d;
            oe_q    <= oe_d;
            cnt_q   <= cnt_d;
            wptr_q  <= wptr_d;
            rptr_q  <= rptr_d;
        end
    end

    assign fd_o  = fdo_q;
    assign fd_oe = oe_q;

    mode_reset_a: assert property (@(posedge clk_sys) $past(sys_rst) |-> cfg_q.mode == MODE_PORT)
        else $error("Mode not general port after reset.");
    mode_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_take && avs_address == OFS_CONFIG && avs_byteenable[0]
        |=> cfg_q.mode == $past(avs_writedata[1:0]))
        else $error("Mode field did not take the written value.");
    bus_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(req) && st_q == ST_IDLE |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus answer not after one wait cycle.");
    select_gate_a: assert property (@(posedge interface_clock) disable iff (l_rst)
        p2_q.cs_n |-> !wr_ev && !rd_ev && !commit_ev ##1 !fd_oe)
        else $error("Strobe acted without chip select.");
    write_ptr_a: assert property (@(posedge interface_clock) disable iff (l_rst)
        wr_ev |=> wptr_q[$past(p2_q.sel)] == $past(wptr_q[p2_q.sel]) + 1'b1)
        else $error("Write pointer did not advance.");
    auto_commit_a: assert property (@(posedge interface_clock) disable iff (l_rst)
        auto_hit |=> cnt_q[$past(p2_q.sel)] == 11'h000 && ptgl_q != $past(ptgl_q))
        else $error("Auto commit missed at programmed length.");
    commit_len_a: assert property (@(posedge interface_clock) disable iff (l_rst)
        commit_ev && !auto_hit && new_cnt != 11'h000 |=> pkt_q.len == $past(new_cnt))
        else $error("Commit length wrong.");
    short_drop_a: assert property (@(posedge interface_clock) disable iff (l_rst)
        auto_hit && l_cfg_q.auto_len == new_cnt |=> pkt_q.len == $past(l_cfg_q.auto_len))
        else $error("Same-edge short commit not dropped.");
    ecc_byte_a: assert property (@(posedge interface_clock) disable iff (l_rst)
        l_cfg_q.word_wide && !pkt_go |=> ecc_q == $past(ecc_q))
        else $error("Check code ran in word-wide mode.");
endmodule
`default_nettype wire

// *** tb/sfc_ext_master.sv ***
/*
 * External master model that drives the slave FIFO link pins.
 * Assumes the bench supplies the link clock and calls cyc once per link cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module sfc_ext_master
    import sfc_pkg::*;
(
    input  wire logic               interface_clock,
    output var  sfc_pkg::sfc_pins_t pins
);
    initial pins = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0};

    // Drives one link cycle; a released data bus shows the inverse of its last value.
    task automatic cyc(input logic [1:0] sel, input logic cs_n, input logic wr, input logic cm,
                       input logic [15:0] d);
        @(posedge interface_clock);
        pins.cs_n   <= cs_n;
        pins.wr     <= wr;
        pins.commit <= cm;
        pins.sel    <= sel;
        pins.oe     <= 1'b0;
        pins.rd     <= 1'b0;
        pins.data   <= wr ? d : ~pins.data;
    endtask

    // Drives one read-side link cycle with chip select low and the write strobe low.
    task automatic rcyc(input logic [1:0] sel, input logic oe, input logic rd);
        @(posedge interface_clock);
        pins.cs_n   <= 1'b0;
        pins.wr     <= 1'b0;
        pins.commit <= 1'b0;
        pins.sel    <= sel;
        pins.oe     <= oe;
        pins.rd     <= rd;
        pins.data   <= ~pins.data;
    endtask
endmodule
`default_nettype wire

// *** tb/sfc_slave_fifo_tb.sv ***
/*
 * Self-checking bench for the slave FIFO packet-commit port.
 * Assumes the design package and the external master model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module sfc_slave_fifo_tb;
    import sfc_pkg::*;
    localparam logic [1:0] MD [3] = '{MODE_PORT, MODE_WAVE, MODE_SLAVE};
    logic               clk_sys, sys_rst, interface_clock;
    logic [4:0]         avs_address;
    logic               avs_read, avs_write, avs_waitrequest;
    logic [31:0]        avs_writedata, avs_readdata, rdata, cnt_e;
    logic [3:0]         avs_byteenable;
    logic [7:0]         ecc_e;
    logic [15:0]        fd_o;
    logic               fd_oe;
    sfc_pins_t          pins;
    int                 err_count, cmp_count;

    sfc_ext_master m (.interface_clock(interface_clock), .pins(pins));

    sfc_slave_fifo DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .interface_clock(interface_clock),
        .slave_chip_select_n(pins.cs_n), .slave_write_strobe(pins.wr),
        .slave_read_strobe(pins.rd), .slave_output_enable(pins.oe),
        .packet_commit_strobe(pins.commit), .fifo_select_lines(pins.sel),
        .fd_i(pins.data), .fd_o(fd_o), .fd_oe(fd_oe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        interface_clock = 1'b0;
        #7;
        forever #40 interface_clock = ~interface_clock;
    end

    task automatic close_out;
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon-MM access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask

    task automatic cfg(input logic [31:0] v);
        bus(1'b1, OFS_CONFIG, v);
        repeat (10) @(posedge interface_clock);
    endtask

    function automatic logic [31:0] lp(input logic [1:0] f, input logic [10:0] n);
        return {18'h0, f, 1'b0, n};
    endfunction

    // Writes n elements; commit with the last one (gap 0), after gap idle cycles, or never.
    task automatic pkt(input logic [1:0] s, input logic c, input int n, input int gap);
        logic [15:0] d;
        ecc_e = 8'h00;
        for (int i = 0; i < n; i++) begin
            d = 16'hC300 | 16'(8'h11 * (i + 1));
            ecc_e ^= d[7:0];
            m.cyc(s, c, 1'b1, (gap == 0) && (i == n - 1), d);
        end
        repeat (gap) m.cyc(s, c, 1'b0, 1'b0, 16'h0);
        if (gap > 0) m.cyc(s, c, 1'b0, 1'b1, 16'h0);
        m.cyc(s, 1'b1, 1'b0, 1'b0, 16'h0);
        repeat (12) @(posedge interface_clock);
    endtask

    initial begin
        #200_000;
        err_count++;
        close_out;
    end

    initial begin
        sys_rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        err_count = 0;
        cmp_count = 0;
        cnt_e = 32'h0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rchk(OFS_CONFIG, 32'h0);
        rchk(OFS_AUTO_LEN, {21'h0, AUTO_LEN_RST});
        rchk(5'h14, 32'h0);
        rchk(OFS_COMMIT_CNT, 32'h0);
        for (int k = 0; k < 3; k++) begin
            cfg({30'h0, MD[k]});
            rchk(OFS_CONFIG, {30'h0, MD[k]});
            pkt(2'h1, 1'b0, 2, 0);
            if (MD[k] == MODE_SLAVE) cnt_e++;
            rchk(OFS_COMMIT_CNT, cnt_e);
        end
        pkt(2'h1, 1'b1, 3, 0);
        rchk(OFS_COMMIT_CNT, cnt_e);
        pkt(2'h2, 1'b0, 4, 0);
        cnt_e++;
        rchk(OFS_COMMIT_CNT, cnt_e);
        rchk(OFS_LAST_PKT, lp(2'h2, 11'd4));
        rchk(OFS_ECC, {24'h0, ecc_e});
        repeat (5) m.rcyc(2'h2, 1'b1, 1'b0);
        @(negedge interface_clock);
        check({31'h0, fd_oe}, 32'h1);
        check({16'h0, fd_o}, 32'h0000_C311);
        m.rcyc(2'h2, 1'b1, 1'b1);
        repeat (4) m.rcyc(2'h2, 1'b1, 1'b0);
        @(negedge interface_clock);
        check({16'h0, fd_o}, 32'h0000_C322);
        m.cyc(2'h2, 1'b1, 1'b0, 1'b0, 16'h0);
        repeat (4) @(posedge interface_clock);
        @(negedge interface_clock);
        check({31'h0, fd_oe}, 32'h0);
        pkt(2'h3, 1'b0, 3, 2);
        cnt_e++;
        rchk(OFS_LAST_PKT, lp(2'h3, 11'd3));
        cfg(32'h07);
        repeat (3) m.cyc(2'h3, 1'b0, 1'b1, 1'b0, 16'h00A5);
        repeat (3) m.cyc(2'h3, 1'b0, 1'b0, 1'b0, 16'h0);
        repeat (3) m.cyc(2'h3, 1'b0, 1'b0, 1'b1, 16'h0);
        m.cyc(2'h3, 1'b1, 1'b0, 1'b0, 16'h0);
        repeat (12) @(posedge interface_clock);
        cnt_e++;
        rchk(OFS_LAST_PKT, lp(2'h3, 11'd1));
        bus(1'b1, OFS_AUTO_LEN, 32'h4);
        repeat (10) @(posedge interface_clock);
        cfg(32'h13);
        pkt(2'h0, 1'b0, 4, -1);
        cnt_e++;
        rchk(OFS_COMMIT_CNT, cnt_e);
        rchk(OFS_LAST_PKT, lp(2'h0, 11'd4));
        pkt(2'h0, 1'b0, 1, 1);
        cnt_e++;
        rchk(OFS_COMMIT_CNT, cnt_e);
        rchk(OFS_LAST_PKT, lp(2'h0, 11'd1));
        cfg(32'h0B);
        pkt(2'h1, 1'b0, 3, 0);
        cnt_e++;
        rchk(OFS_LAST_PKT, lp(2'h1, 11'd6));
        rchk(OFS_ECC, 32'h0);
        pkt(2'h1, 1'b0, 0, 1);
        rchk(OFS_COMMIT_CNT, cnt_e);
        close_out;
    end
endmodule
`default_nettype wire
